/* File: logic/acc_pkg.sv */
// package: register map, field layout and reset values of the conversion control block
package acc_pkg;

  // ==========================================================================
  // register indices and byte addresses
  // ==========================================================================
  // printed offsets are not word aligned, so each one is an index
  localparam logic [9:0] ACC_IDX_CONTROL = 10'h0E1;
  localparam logic [9:0] ACC_IDX_RESULT_HIGH = 10'h0E2;
  localparam logic [9:0] ACC_IDX_IRQ_STATUS = 10'h0F0;
  localparam logic [9:0] ACC_IDX_IRQ_ENABLE = 10'h0F1;
  localparam logic [9:0] ACC_IDX_IRQ_CLEAR = 10'h0F2;
  localparam int ACC_ADDR_W = 12;
  localparam int ACC_IDX_LSB = 2;

  // ==========================================================================
  // control register fields
  // ==========================================================================
  localparam int ACC_CTL_RES_HI = 7;
  localparam int ACC_CTL_RES_LO = 6;
  localparam int ACC_CTL_EXT_EN = 5;
  localparam int ACC_CTL_DONE = 4;
  localparam int ACC_CTL_BUSY = 3;
  localparam int ACC_CTL_CHAN_HI = 2;
  localparam int ACC_CTL_CHAN_LO = 0;

  // ==========================================================================
  // interrupt status bits
  // ==========================================================================
  localparam int ACC_EVT_DONE = 0;
  localparam int ACC_EVT_BLOCKED = 1;
  localparam int ACC_EVT_N = 2;

  // ==========================================================================
  // widths, reset values and bus answers
  // ==========================================================================
  localparam int ACC_RES_W = 10;
  localparam int ACC_CHAN_W = 3;
  localparam int ACC_REG_W = 8;
  localparam logic [2:0] ACC_CHAN_RST = 3'h0;
  localparam logic [9:0] ACC_RES_RST = 10'h000;
  localparam logic [1:0] ACC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;
  localparam logic [31:0] ACC_DATA_ZERO = 32'h0000_0000;

  typedef enum logic {ACC_ST_IDLE, ACC_ST_CONV} acc_state_t;

endpackage

/* File: logic/acc_axil_slave.sv */
// file: AXI4-Lite slave front end handing single-word accesses to the register file
`timescale 1ns/100ps
module acc_axil_slave
  import acc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ACC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ACC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [ACC_ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_hit,
  output logic [ACC_ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_hit
);

  logic aw_have_q;
  logic w_have_q;
  logic rd_pend_q;

  // a write fires once both halves are held and no response is pending
  assign wr_en = aw_have_q && w_have_q && !s_axi_bvalid;

  // ==========================================================================
  // write address and data capture, either order
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      wr_addr <= '0;
      wr_data <= ACC_DATA_ZERO;
      wr_strb <= 4'h0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        s_axi_awready <= 1'b0;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        s_axi_wready <= 1'b0;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
    end
  end

  // write response: unmapped addresses answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ACC_RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // read channel: data is sampled one cycle after the address is taken
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      rd_pend_q <= 1'b0;
      rd_addr <= '0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= ACC_DATA_ZERO;
      s_axi_rresp <= ACC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        rd_pend_q <= 1'b1;
        rd_addr <= s_axi_araddr;
      end
      if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_hit ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

/* File: logic/acc_irq.sv */
// file: sticky event status, enable mask and level interrupt output
`timescale 1ns/100ps
module acc_irq
  import acc_pkg::*;
#(
  parameter int N = ACC_EVT_N
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [N-1:0] evt,
  input wire logic enable_wr,
  input wire logic clear_wr,
  input wire logic [N-1:0] wdata,
  output logic [N-1:0] status_q,
  output logic [N-1:0] enable_q,
  output logic irq_q
);

  // ==========================================================================
  // per-bit sticky status; a new event beats a clear in the same cycle
  // ==========================================================================
  for (genvar i = 0; i < N; i++) begin : g_bit
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        status_q[i] <= 1'b0;
      end else if (evt[i]) begin
        status_q[i] <= 1'b1;
      end else if (clear_wr && wdata[i]) begin
        status_q[i] <= 1'b0;
      end
    end
  end

  // enable mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= '0;
    end else if (enable_wr) begin
      enable_q <= wdata;
    end
  end

  // registered level output, one cycle behind status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & enable_q);
    end
  end

endmodule

/* File: logic/acc_top.sv */
// file: top level of the converter control and status block with its register file
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps

module acc_top
  import acc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ACC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ACC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_start_input,
  output logic [ACC_CHAN_W-1:0] channel_select_q,
  output logic conv_start_q,
  input wire logic conv_finish,
  input wire logic [ACC_RES_W-1:0] conv_data,
  output logic irq_q
);

  // ==========================================================================
  // bus front end wiring
  // ==========================================================================
  logic wr_en;
  logic [ACC_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic [ACC_ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [9:0] wr_idx;
  logic [9:0] rd_idx;

  acc_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_hit(wr_hit),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  // ==========================================================================
  // address decode
  // ==========================================================================
  // word index; byte offset bits below it are ignored
  assign wr_idx = wr_addr[ACC_ADDR_W-1:ACC_IDX_LSB];
  assign rd_idx = rd_addr[ACC_ADDR_W-1:ACC_IDX_LSB];

  logic wr_ctrl;
  logic wr_irq_en;
  logic wr_irq_clr;

  // registers sit in byte lane 0, so a write without that lane does nothing
  assign wr_ctrl = wr_en && wr_strb[0] && (wr_idx == ACC_IDX_CONTROL);
  assign wr_irq_en = wr_en && wr_strb[0] && (wr_idx == ACC_IDX_IRQ_ENABLE);
  assign wr_irq_clr = wr_en && wr_strb[0] && (wr_idx == ACC_IDX_IRQ_CLEAR);

  // the result register is read-only but answers okay to a write
  assign wr_hit = (wr_idx == ACC_IDX_CONTROL) || (wr_idx == ACC_IDX_RESULT_HIGH) ||
                  (wr_idx == ACC_IDX_IRQ_STATUS) || (wr_idx == ACC_IDX_IRQ_ENABLE) ||
                  (wr_idx == ACC_IDX_IRQ_CLEAR);

  // ==========================================================================
  // converter state
  // ==========================================================================
  acc_state_t state_q;
  logic done_q;
  logic ext_en_q;
  logic ext_prev_q;
  logic [ACC_RES_W-1:0] result_q;
  logic busy;
  logic idle;
  logic ext_rise;
  logic ext_req;
  logic sw_req;
  logic sw_start;
  logic ext_start;
  logic start;
  logic finish;
  logic blocked;

  assign busy = (state_q == ACC_ST_CONV);
  assign idle = !done_q && !busy;

  // a held level would retrigger after every clear, so only the edge counts
  assign ext_rise = external_start_input && !ext_prev_q;
  assign ext_req = ext_en_q && ext_rise;
  assign sw_req = wr_ctrl && wr_data[ACC_CTL_BUSY];

  // a write that clears done and sets busy together may restart at once
  assign sw_start = sw_req && !busy &&
                    (!done_q || !wr_data[ACC_CTL_DONE]);
  assign ext_start = ext_req && idle;
  assign start = sw_start || ext_start;
  // a finish pulse counts only while converting; a stray one from an idle
  // converter can neither set done nor overwrite the held result
  assign finish = busy && conv_finish;

  // requests that arrive while the converter cannot take them are dropped
  assign blocked = (sw_req || ext_req) && !start;

  // remembers the pin level for the edge detector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= external_start_input;
    end
  end

  // sequencer: idle until a start, converting until the converter reports
  // there is no timeout: a converter that never reports leaves the block busy,
  // and only reset brings it back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ACC_ST_IDLE;
    end else begin
      case (state_q)
        ACC_ST_IDLE: begin
          if (start) begin
            state_q <= ACC_ST_CONV;
          end
        end
        ACC_ST_CONV: begin
          if (conv_finish) begin
            state_q <= ACC_ST_IDLE;
          end
        end
        default: begin
          state_q <= ACC_ST_IDLE;
        end
      endcase
    end
  end

  // one-cycle start pulse toward the converter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_start_q <= 1'b0;
    end else begin
      conv_start_q <= start;
    end
  end

  // done flag: completion sets it and wins over a clear in the same cycle
  // the trade-off: a clear written as a conversion ends is lost, never the result
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
    end else if (finish) begin
      done_q <= 1'b1;
    end else if (wr_ctrl && !wr_data[ACC_CTL_DONE]) begin
      done_q <= 1'b0;
    end
  end

  // result captured whole in the cycle the done flag rises
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_q <= ACC_RES_RST;
    end else if (finish) begin
      result_q <= conv_data;
    end
  end

  // external start enable is plain read/write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_en_q <= 1'b0;
    end else if (wr_ctrl) begin
      ext_en_q <= wr_data[ACC_CTL_EXT_EN];
    end
  end

  // channel select follows a write only when the converter was idle
  // idle is judged before the write, so a write that starts a conversion from idle
  // still converts on the channel that it writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_select_q <= ACC_CHAN_RST;
    end else if (wr_ctrl && idle) begin
      channel_select_q <= wr_data[ACC_CTL_CHAN_HI:ACC_CTL_CHAN_LO];
    end
  end

  // ==========================================================================
  // interrupt
  // ==========================================================================
  logic [ACC_EVT_N-1:0] evt;
  logic [ACC_EVT_N-1:0] irq_status;
  logic [ACC_EVT_N-1:0] irq_enable;

  assign evt[ACC_EVT_DONE] = finish;
  assign evt[ACC_EVT_BLOCKED] = blocked;

  acc_irq #(
    .N(ACC_EVT_N)
  ) u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .evt(evt),
    .enable_wr(wr_irq_en),
    .clear_wr(wr_irq_clr),
    .wdata(wr_data[ACC_EVT_N-1:0]),
    .status_q(irq_status),
    .enable_q(irq_enable),
    .irq_q(irq_q)
  );

  // ==========================================================================
  // read mux
  // ==========================================================================
  logic [ACC_REG_W-1:0] ctrl_view;

  // low result bits ride in the top of the control register
  always_comb begin
    ctrl_view = '0;
    ctrl_view[ACC_CTL_RES_HI:ACC_CTL_RES_LO] = result_q[1:0];
    ctrl_view[ACC_CTL_EXT_EN] = ext_en_q;
    ctrl_view[ACC_CTL_DONE] = done_q;
    ctrl_view[ACC_CTL_BUSY] = busy;
    ctrl_view[ACC_CTL_CHAN_HI:ACC_CTL_CHAN_LO] = channel_select_q;
  end

  // the clear register is write-only and reads as zero
  // decoded from the address held by the front end; the bus registers the
  // word one cycle later, so a flag that moves in that cycle reads late
  always_comb begin
    rd_data = ACC_DATA_ZERO;
    rd_hit = 1'b1;
    case (rd_idx)
      ACC_IDX_CONTROL: begin
        rd_data[ACC_REG_W-1:0] = ctrl_view;
      end
      ACC_IDX_RESULT_HIGH: begin
        rd_data[ACC_REG_W-1:0] = result_q[ACC_RES_W-1:2];
      end
      ACC_IDX_IRQ_STATUS: begin
        rd_data[ACC_EVT_N-1:0] = irq_status;
      end
      ACC_IDX_IRQ_ENABLE: begin
        rd_data[ACC_EVT_N-1:0] = irq_enable;
      end
      ACC_IDX_IRQ_CLEAR: begin
        rd_data = ACC_DATA_ZERO;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

endmodule

/* File: verif/acc_chk.sv */
// checker: port-level assertions of the converter control block
`timescale 1ns/100ps
module acc_chk
  import acc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic [ACC_CHAN_W-1:0] channel_select_q,
  input wire logic conv_start_q,
  input wire logic conv_finish
);
  logic busy_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================
  // conversion tracking
  // ==========================================
  // busy is rebuilt from the pins, so no register read is needed; rises one cycle after the design, falls with it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'h0;
    end else if (conv_start_q) begin
      busy_q <= 1'h1;
    end else if (conv_finish) begin
      busy_q <= 1'h0;
    end
  end
  sequence start_s;
    conv_start_q;
  endsequence
  sequence finish_s;
    busy_q && conv_finish;
  endsequence
  // ==========================================
  // assertions
  // ==========================================
  start_pulse_a: assert property (start_s |=> !conv_start_q)
    else $error("start pulse longer than one cycle");
  busy_block_a: assert property (busy_q |-> !conv_start_q)
    else $error("start issued while converting");
  chan_hold_a: assert property (busy_q |-> $stable(channel_select_q))
    else $error("channel changed while converting");
  // a write that clears done and sets busy may restart at once; it shows as bvalid rising
  done_block_a: assert property (finish_s |=> !conv_start_q ##1
    (!conv_start_q || $rose(s_axi_bvalid))) else $error("start right after completion");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid) else $error("write response missing");
  wr_hold_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted before response taken");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
    else $error("read data missing");
  rd_err_a: assert property (s_axi_rvalid && s_axi_rresp == ACC_RESP_SLVERR
    |-> s_axi_rdata == ACC_DATA_ZERO) else $error("error read carries data");
endmodule
bind acc_top acc_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .channel_select_q, .conv_start_q, .conv_finish);

/* File: verif/acc_conv_model.sv */
// partner model: analog converter answering start pulses after a chosen delay
`timescale 1ns/100ps
module acc_conv_model
  import acc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ACC_CHAN_W-1:0] channel_select_q,
  input wire logic conv_start_q,
  input wire logic [7:0] delay,
  output logic conv_finish,
  output logic [ACC_RES_W-1:0] conv_data
);
  logic [7:0] cnt_q;
  logic [ACC_CHAN_W-1:0] chan_q;
  logic run_q;
  // result toggles outside the finish cycle so a sample one cycle late sees the inverted value
  always_ff @(posedge aclk) begin
    conv_finish <= 1'h0;
    conv_data <= ~conv_data;
    if (!aresetn) begin
      run_q <= 1'h0;
      conv_data <= 10'h155;
    end else if (conv_start_q) begin
      run_q <= 1'h1;
      cnt_q <= delay;
      chan_q <= channel_select_q;
    end else if (run_q && cnt_q == 8'h00) begin
      run_q <= 1'h0;
      conv_finish <= 1'h1;
      conv_data <= {chan_q, 7'h15};
    end else if (run_q) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule

/* File: verif/test_adc_conversion_control.sv */
// testbench: register access, conversion flow, start blocking and interrupt of the block
`timescale 1ns/100ps
module test_adc_conversion_control
  import acc_pkg::*;
;
  typedef struct packed {logic [2:0] ch; logic pin; logic slow; logic [7:0] res;} acc_row_t;
  localparam logic [11:0] A_CTL = {ACC_IDX_CONTROL, 2'h0};
  localparam logic [11:0] A_RES = {ACC_IDX_RESULT_HIGH, 2'h0};
  localparam logic [11:0] A_STA = {ACC_IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] A_ENA = {ACC_IDX_IRQ_ENABLE, 2'h0};
  localparam logic [11:0] A_CLR = {ACC_IDX_IRQ_CLEAR, 2'h0};
  acc_row_t rows [8] = '{13'h0005, 13'h0625, 13'h0945, 13'h0F65, 13'h1085, 13'h16A5, 13'h19C5,
    13'h1FE5};
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, external_start_input = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [7:0] delay = 8'h02;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic conv_start_q, conv_finish, irq_q;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd;
  logic [2:0] channel_select_q;
  logic [9:0] conv_data;
  int error_cnt = 0, check_count = 0, starts = 0, n0 = 0;
  acc_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .external_start_input, .channel_select_q, .conv_start_q, .conv_finish,
    .conv_data, .irq_q);
  acc_conv_model u_conv (.aclk, .aresetn, .channel_select_q, .conv_start_q, .delay,
    .conv_finish, .conv_data);
  // ==========================================
  // clock, start counter and hang guard
  // ==========================================
  always #4 aclk = ~aclk;
  // counting pulses catches both lost and doubled starts
  always @(posedge aclk) begin
    if (conv_start_q === 1'h1) starts <= starts + 1;
  end
  // whole run needs well under a thousand cycles, so this ceiling only trips on a hang
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    summarize();
  end
  // ==========================================
  // tasks
  // ==========================================
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // each channel is released on its own handshake; the edge wait up front avoids double drives
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic got;
    got = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!got) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
        got = 1'h1;
      end
    end
  endtask
  task automatic rd_reg(input logic [11:0] a);
    logic got;
    got = 1'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!got) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) begin
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        got = 1'h1;
      end
    end
  endtask
  task automatic rc(input string name, input logic [11:0] a, input logic [31:0] exp);
    rd_reg(a);
    chk(name, exp, rd);
  endtask
  task automatic wait_done();
    do rd_reg(A_CTL); while (rd[ACC_CTL_DONE] !== 1'h1);
  endtask
  task automatic pin_pulse();
    @(posedge aclk);
    external_start_input <= 1'h1;
    repeat (2) @(posedge aclk); // held two cycles, longer than the minimum
    external_start_input <= 1'h0;
  endtask
  // ==========================================
  // main sequence
  // ==========================================
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    chk("start pulse", 32'h0, conv_start_q);
    chk("irq", 32'h0, irq_q);
    rc("control", A_CTL, 32'h0);
    rc("result high", A_RES, 32'h0);
    rc("irq enable", A_ENA, 32'h0);
    wr(A_ENA, 8'h01);
    // one conversion per channel, alternating software and pin starts
    for (int i = 0; i < 8; i++) begin
      delay <= rows[i].slow ? 8'h14 : 8'h02;
      wr(A_CTL, {2'h0, rows[i].pin, 5'h00});
      wr(A_CTL, {2'h0, rows[i].pin, 1'h0, ~rows[i].pin, rows[i].ch});
      if (rows[i].pin) pin_pulse();
      // low result bits still hold the previous conversion, which the model fixes at 01
      if (rows[i].slow) rc("busy", A_CTL, {24'h0, 2'h1, rows[i].pin, 2'h1, rows[i].ch});
      wait_done();
      chk("channel", rows[i].ch, channel_select_q);
      chk("control", {24'h0, rows[i].res[1:0], rows[i].pin, 2'h2, rows[i].ch}, rd);
      rc("result high", A_RES, rows[i].res);
      rc("irq status", A_STA, 32'h1);
      chk("irq", 32'h1, irq_q);
    end
    // done still set: start, channel change and pin start are all refused
    n0 = starts;
    wr(A_CTL, 8'h3A);
    pin_pulse();
    rc("control", A_CTL, 32'h77);
    chk("starts", n0, starts);
    rc("irq status", A_STA, 32'h3);
    // clearing done in the starting write restarts on the old channel
    wr(A_CTL, 8'h28);
    wait_done();
    chk("channel", 32'h7, channel_select_q);
    chk("starts", n0 + 1, starts);
    // second start while busy is ignored
    delay <= 8'h14;
    wr(A_CTL, 8'h00);
    wr(A_CTL, 8'h0B);
    wr(A_CTL, 8'h0D);
    wait_done();
    chk("starts", n0 + 2, starts);
    chk("channel", 32'h3, channel_select_q);
    rc("result high", A_RES, 32'h65);
    // pin ignored while its enable is clear, and software cannot set done
    wr(A_CTL, 8'h00);
    pin_pulse();
    repeat (8) @(posedge aclk);
    rc("control", A_CTL, 32'h43);
    wr(A_CTL, 8'h13);
    rc("control", A_CTL, 32'h43);
    chk("starts", n0 + 2, starts);
    // interrupt clear and mask
    wr(A_CLR, 8'h01);
    rc("irq status", A_STA, 32'h2);
    chk("irq", 32'h0, irq_q);
    wr(A_ENA, 8'h02);
    rd_reg(A_ENA);
    chk("irq", 32'h1, irq_q);
    wr(A_ENA, 8'h00);
    rd_reg(A_ENA);
    chk("irq", 32'h0, irq_q);
    wr(A_CLR, 8'h03);
    rc("irq status", A_STA, 32'h0);
    // unmapped place and read-only result
    wr(12'h3FC, 8'hFF);
    chk("write resp", {30'h0, ACC_RESP_SLVERR}, {30'h0, resp});
    rc("unmapped", 12'h3FC, 32'h0);
    chk("read resp", {30'h0, ACC_RESP_SLVERR}, {30'h0, resp});
    wr(A_RES, 8'hFF);
    rc("result high", A_RES, 32'h65);
    // reset in mid-conversion brings every register back to its idle value
    wr(A_ENA, 8'h01);
    wr(A_CTL, 8'h2D);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    chk("channel", 32'h0, channel_select_q);
    chk("irq", 32'h0, irq_q);
    rc("control", A_CTL, 32'h0);
    rc("result high", A_RES, 32'h0);
    rc("irq enable", A_ENA, 32'h0);
    rc("irq status", A_STA, 32'h0);
    summarize();
  end
endmodule
